/* rtl/clms_pkg.sv */
package clms_pkg;

  // Five-value line state held per cache line.
  typedef enum logic [2:0] {
    LINE_I  = 3'h0,
    LINE_UC = 3'h1,
    LINE_UD = 3'h2,
    LINE_SC = 3'h3,
    LINE_SD = 3'h4
  } clms_line_type;

  // Maintenance operation requested on the user port.
  typedef enum logic [1:0] {
    OP_CLEAN_SHARED  = 2'h0,
    OP_CLEAN_INVALID = 2'h1,
    OP_MAKE_UNIQUE   = 2'h2,
    OP_MAKE_INVALID  = 2'h3
  } clms_op_type;

  typedef enum logic [2:0] {
    FSM_IDLE = 3'h0,
    FSM_WB   = 3'h1,
    FSM_AR   = 3'h2,
    FSM_RESP = 3'h3
  } clms_fsm_type;

  // Snoop codes driven with the read address request.
  localparam logic [3:0] SNOOP_CLEAN_SHARED  = 4'h8;
  localparam logic [3:0] SNOOP_CLEAN_INVALID = 4'h9;
  localparam logic [3:0] SNOOP_MAKE_UNIQUE   = 4'hC;
  localparam logic [3:0] SNOOP_MAKE_INVALID  = 4'hD;

  // Bit positions inside the four-bit read response.
  localparam int RESP_IS_SHARED_BIT = 3;
  localparam int RESP_PASS_DIRTY_BIT = 2;

  localparam clms_line_type LINE_RESET = LINE_I;
  localparam int NUM_LINES_DEFAULT = 8;

  function automatic logic line_dirty(clms_line_type s);
    return (s == LINE_UD) || (s == LINE_SD);
  endfunction

  // A store dirties a valid line; only a full-line store may allocate.
  function automatic clms_line_type line_store(clms_line_type s,
                                               logic full);
    clms_line_type r;
    r = s;
    case (s)
      LINE_UC: r = LINE_UD;
      LINE_SC: r = LINE_SD;
      LINE_I: r = full ? LINE_UD : LINE_I;
      default: r = s;
    endcase
    return r;
  endfunction

endpackage

/* rtl/clms_resp_update.sv */
`timescale 1ns/1ps
module clms_resp_update (
  input wire clms_pkg::clms_op_type op,
  input wire clms_pkg::clms_line_type cur,
  input wire logic resp_shared,
  output clms_pkg::clms_line_type nxt
);

  always_comb begin
    nxt = cur;
    case (op)
      clms_pkg::OP_CLEAN_SHARED: begin
        // A dirty state here can only come from a local store.
        case (cur)
          clms_pkg::LINE_SC: begin
            nxt = resp_shared ? clms_pkg::LINE_SC : clms_pkg::LINE_UC;
          end
          clms_pkg::LINE_SD: begin
            nxt = resp_shared ? clms_pkg::LINE_SD : clms_pkg::LINE_UD;
          end
          clms_pkg::LINE_UC: begin
            // Another holder was reported, so the copy is no longer unique.
            nxt = resp_shared ? clms_pkg::LINE_SC : clms_pkg::LINE_UC;
          end
          clms_pkg::LINE_UD: begin
            nxt = resp_shared ? clms_pkg::LINE_SD : clms_pkg::LINE_UD;
          end
          default: nxt = cur;
        endcase
      end
      clms_pkg::OP_MAKE_UNIQUE: begin
        // The full-line store commits with the completion.
        nxt = clms_pkg::LINE_UD;
      end
      clms_pkg::OP_CLEAN_INVALID: nxt = clms_pkg::LINE_I;
      clms_pkg::OP_MAKE_INVALID: nxt = clms_pkg::LINE_I;
      default: nxt = cur;
    endcase
  end

endmodule

/* rtl/clms_top.sv */
`timescale 1ns/1ps
// Function
// - A line held dirty is written clean before CleanShared is issued.
// - Local stores may dirty the line while CleanShared is outstanding.
// - CleanShared keeps I as I, turns SC into UC on 00 and keeps SC on 10.
// - A UC line stays UC on CleanShared answered 00, turns SC on 10, and turns dirty only by a store.
// - CleanInvalid on a dirty line first writes it back, then invalidates.
// - CleanInvalid is issued only from I, is answered 00 and leaves I.
// - Make operations go out on the read address channel.
// - MakeUnique is issued only for a full-line store coupled to completion.
// - MakeUnique from I, SC or SD ends UD on response 00.
// - MakeUnique from UC or UD also ends UD on response 00.
// - Any valid line is invalidated before MakeInvalid is issued.
// - MakeInvalid from I is answered 00 and the line stays I.
module clms_top #(
  parameter int NUM_LINES = clms_pkg::NUM_LINES_DEFAULT,
  parameter int IW = $clog2(NUM_LINES)
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire clms_pkg::clms_op_type req_op,
  input wire logic [IW-1:0] req_idx,
  input wire logic req_full,
  output logic req_ready,
  output logic req_reject,
  output logic done,
  output logic resp_err,
  input wire logic st_valid,
  input wire logic [IW-1:0] st_idx,
  input wire logic st_full,
  output logic wb_valid,
  output logic [IW-1:0] wb_idx,
  output logic wb_keep,
  input wire logic wb_ready,
  output logic ar_valid,
  output logic [3:0] ar_snoop,
  output logic [IW-1:0] ar_idx,
  input wire logic ar_ready,
  input wire logic r_valid,
  input wire logic [3:0] r_resp,
  output logic r_ready,
  input wire logic [IW-1:0] rd_idx,
  output clms_pkg::clms_line_type rd_state
);

  typedef struct packed {
    clms_pkg::clms_fsm_type fsm;
    clms_pkg::clms_line_type [NUM_LINES-1:0] lines;
    clms_pkg::clms_op_type op;
    logic [IW-1:0] idx;
    logic [3:0] snoop;
    logic req_ready;
    logic reject;
    logic done;
    logic err;
    logic wb_valid;
    logic wb_keep;
    logic ar_valid;
    logic r_ready;
    clms_pkg::clms_line_type rd_state;
  } clms_state_type;

  clms_state_type q;
  clms_state_type d;
  clms_pkg::clms_line_type resp_next;
  clms_pkg::clms_line_type cur_line;
  logic resp_take;
  logic store_blocked;

  function automatic logic [3:0] op_snoop(clms_pkg::clms_op_type op);
    logic [3:0] r;
    r = clms_pkg::SNOOP_CLEAN_SHARED;
    case (op)
      clms_pkg::OP_CLEAN_SHARED: r = clms_pkg::SNOOP_CLEAN_SHARED;
      clms_pkg::OP_CLEAN_INVALID: r = clms_pkg::SNOOP_CLEAN_INVALID;
      clms_pkg::OP_MAKE_UNIQUE: r = clms_pkg::SNOOP_MAKE_UNIQUE;
      clms_pkg::OP_MAKE_INVALID: r = clms_pkg::SNOOP_MAKE_INVALID;
      default: r = clms_pkg::SNOOP_CLEAN_SHARED;
    endcase
    return r;
  endfunction

  function automatic clms_pkg::clms_line_type line_clean(
      clms_pkg::clms_line_type s);
    clms_pkg::clms_line_type r;
    r = s;
    case (s)
      clms_pkg::LINE_UD: r = clms_pkg::LINE_UC;
      clms_pkg::LINE_SD: r = clms_pkg::LINE_SC;
      default: r = s;
    endcase
    return r;
  endfunction

  function automatic logic op_invalidates(clms_pkg::clms_op_type op);
    return (op == clms_pkg::OP_CLEAN_INVALID) ||
           (op == clms_pkg::OP_MAKE_INVALID);
  endfunction

  assign cur_line = q.lines[q.idx];
  assign resp_take = (q.fsm == clms_pkg::FSM_RESP) && q.r_ready && r_valid;

  // An invalidating operation owns its line from acceptance until the answer
  // is back, so a racing full-line store cannot re-allocate it under the
  // request.
  assign store_blocked = (q.fsm == clms_pkg::FSM_IDLE) ?
    (req_valid && q.req_ready && (st_idx == req_idx) &&
     op_invalidates(req_op)) :
    ((st_idx == q.idx) && op_invalidates(q.op));

  clms_resp_update u_resp (
    .op(q.op),
    .cur(cur_line),
    .resp_shared(r_resp[clms_pkg::RESP_IS_SHARED_BIT]),
    .nxt(resp_next)
  );

  always_comb begin
    d = q;
    d.reject = 1'b0;
    d.done = 1'b0;
    case (q.fsm)
      clms_pkg::FSM_IDLE: begin
        if (req_valid && q.req_ready) begin
          d.op = req_op;
          d.idx = req_idx;
          d.snoop = op_snoop(req_op);
          d.err = 1'b0;
          if (req_op == clms_pkg::OP_MAKE_UNIQUE && !req_full) begin
            d.reject = 1'b1;
          end else if (clms_pkg::line_dirty(q.lines[req_idx]) &&
                       (req_op == clms_pkg::OP_CLEAN_SHARED ||
                        req_op == clms_pkg::OP_CLEAN_INVALID)) begin
            d.fsm = clms_pkg::FSM_WB;
            d.wb_valid = 1'b1;
            d.wb_keep = (req_op == clms_pkg::OP_CLEAN_SHARED);
          end else begin
            if (op_invalidates(req_op)) begin
              d.lines[req_idx] = clms_pkg::LINE_I;
            end
            d.fsm = clms_pkg::FSM_AR;
            d.ar_valid = 1'b1;
          end
        end
      end
      clms_pkg::FSM_WB: begin
        if (wb_ready) begin
          // WriteClean keeps the line clean; WriteBack drops it.
          d.lines[q.idx] = q.wb_keep ? line_clean(cur_line) :
                           clms_pkg::LINE_I;
          d.wb_valid = 1'b0;
          d.fsm = clms_pkg::FSM_AR;
          d.ar_valid = 1'b1;
        end
      end
      clms_pkg::FSM_AR: begin
        if (ar_ready) begin
          d.ar_valid = 1'b0;
          d.r_ready = 1'b1;
          d.fsm = clms_pkg::FSM_RESP;
        end
      end
      clms_pkg::FSM_RESP: begin
        if (r_valid) begin
          d.lines[q.idx] = resp_next;
          d.r_ready = 1'b0;
          d.done = 1'b1;
          // PassDirty must stay low, IsShared too except on CleanShared.
          d.err = r_resp[clms_pkg::RESP_PASS_DIRTY_BIT] ||
                  (r_resp[clms_pkg::RESP_IS_SHARED_BIT] &&
                   q.op != clms_pkg::OP_CLEAN_SHARED);
          d.fsm = clms_pkg::FSM_IDLE;
        end
      end
      default: begin
        d.fsm = clms_pkg::FSM_IDLE;
        d.wb_valid = 1'b0;
        d.ar_valid = 1'b0;
        d.r_ready = 1'b0;
      end
    endcase
    // Local stores land after the maintenance update of the same cycle.
    if (st_valid && !store_blocked) begin
      d.lines[st_idx] = clms_pkg::line_store(d.lines[st_idx], st_full);
    end
    d.req_ready = (d.fsm == clms_pkg::FSM_IDLE);
    d.rd_state = d.lines[rd_idx];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.fsm <= clms_pkg::FSM_IDLE;
      q.lines <= {NUM_LINES{clms_pkg::LINE_RESET}};
      q.op <= clms_pkg::OP_CLEAN_SHARED;
      q.idx <= '0;
      q.snoop <= clms_pkg::SNOOP_CLEAN_SHARED;
      q.req_ready <= 1'b0;
      q.reject <= 1'b0;
      q.done <= 1'b0;
      q.err <= 1'b0;
      q.wb_valid <= 1'b0;
      q.wb_keep <= 1'b0;
      q.ar_valid <= 1'b0;
      q.r_ready <= 1'b0;
      q.rd_state <= clms_pkg::LINE_RESET;
    end else begin
      q <= d;
    end
  end

  assign req_ready = q.req_ready;
  assign req_reject = q.reject;
  assign done = q.done;
  assign resp_err = q.err;
  assign wb_valid = q.wb_valid;
  assign wb_idx = q.idx;
  assign wb_keep = q.wb_keep;
  assign ar_valid = q.ar_valid;
  assign ar_snoop = q.snoop;
  assign ar_idx = q.idx;
  assign r_ready = q.r_ready;
  assign rd_state = q.rd_state;

  a_cs_issue_clean: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(q.ar_valid) && q.op == clms_pkg::OP_CLEAN_SHARED |->
      !clms_pkg::line_dirty(cur_line) || $past(st_valid))
    else $error("CleanShared issued on a dirty line");

  a_ci_from_invalid: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.ar_valid && q.op == clms_pkg::OP_CLEAN_INVALID |->
      cur_line == clms_pkg::LINE_I)
    else $error("CleanInvalid issued from a valid state");

  a_mi_from_invalid: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.ar_valid && q.op == clms_pkg::OP_MAKE_INVALID |->
      cur_line == clms_pkg::LINE_I)
    else $error("MakeInvalid issued from a valid state");

  a_ar_hold_stable: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.ar_valid && !ar_ready |=>
      q.ar_valid && $stable(q.snoop) && $stable(q.idx))
    else $error("Read address request dropped before acceptance");

  a_mu_full_only: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    req_valid && q.req_ready && req_op == clms_pkg::OP_MAKE_UNIQUE &&
      !req_full |=> q.reject && !q.ar_valid ##1 q.req_ready)
    else $error("MakeUnique accepted without a full-line store");

  a_mu_ends_dirty: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    resp_take && q.op == clms_pkg::OP_MAKE_UNIQUE |=>
      q.lines[$past(q.idx)] == clms_pkg::LINE_UD && q.done)
    else $error("MakeUnique did not end UniqueDirty");

  a_cs_sc_update: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    resp_take && q.op == clms_pkg::OP_CLEAN_SHARED &&
      cur_line == clms_pkg::LINE_SC && !(st_valid && st_idx == q.idx) |=>
      q.lines[$past(q.idx)] ==
        ($past(r_resp[3]) ? clms_pkg::LINE_SC : clms_pkg::LINE_UC))
    else $error("CleanShared from SharedClean updated wrongly");

  a_cs_uc_stays: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    resp_take && q.op == clms_pkg::OP_CLEAN_SHARED &&
      cur_line == clms_pkg::LINE_UC && !(st_valid && st_idx == q.idx) &&
      !r_resp[clms_pkg::RESP_IS_SHARED_BIT] |=>
      q.lines[$past(q.idx)] == clms_pkg::LINE_UC)
    else $error("UniqueClean line changed on CleanShared");

  a_cs_uc_shared: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    resp_take && q.op == clms_pkg::OP_CLEAN_SHARED &&
      cur_line == clms_pkg::LINE_UC &&
      r_resp[clms_pkg::RESP_IS_SHARED_BIT] &&
      !(st_valid && st_idx == q.idx) |=>
      q.lines[$past(q.idx)] == clms_pkg::LINE_SC)
    else $error("Shared UniqueClean line not demoted on CleanShared");

  a_inval_stays: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    resp_take && q.op == clms_pkg::OP_MAKE_INVALID |=>
      q.lines[$past(q.idx)] == clms_pkg::LINE_I)
    else $error("MakeInvalid left the line valid");

  a_resp_done: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    resp_take |=> q.done && !q.r_ready ##1 !q.done)
    else $error("Response handshake not completed in one cycle");

  a_store_during_cs: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.fsm == clms_pkg::FSM_AR && q.op == clms_pkg::OP_CLEAN_SHARED &&
      st_valid && st_idx == q.idx && cur_line == clms_pkg::LINE_SC |=>
      q.lines[$past(q.idx)] == clms_pkg::LINE_SD)
    else $error("Local store lost while CleanShared outstanding");

  a_dirty_wb_first: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    req_valid && q.req_ready && req_op == clms_pkg::OP_CLEAN_INVALID &&
      clms_pkg::line_dirty(q.lines[req_idx]) |=>
      q.wb_valid && !q.wb_keep && !q.ar_valid)
    else $error("Dirty line not written back before CleanInvalid");

endmodule

/* tb/clms_ic_model.sv */
`timescale 1ns/1ps
// Interconnect stand-in that answers read-address requests and write-backs.
// A wait count lets the bench make it slow enough to slip stores in.
module clms_ic_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] wait_cyc,
  input wire logic shared,
  input wire logic ar_valid,
  input wire logic [3:0] ar_snoop,
  output logic ar_ready,
  output logic r_valid,
  output logic [3:0] r_resp,
  input wire logic r_ready,
  input wire logic wb_valid,
  output logic wb_ready
);
  logic pend;
  logic is_cs;
  logic [3:0] cnt;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ar_ready <= 1'b0;
      r_valid <= 1'b0;
      r_resp <= 4'hF;
      wb_ready <= 1'b0;
      pend <= 1'b0;
      is_cs <= 1'b0;
      cnt <= 4'h0;
    end else begin
      ar_ready <= 1'b0;
      wb_ready <= wb_valid && !wb_ready;
      if (ar_valid && ar_ready) begin
        pend <= 1'b1;
        is_cs <= (ar_snoop == clms_pkg::SNOOP_CLEAN_SHARED);
      end else if (ar_valid && !pend) begin
        cnt <= cnt + 4'h1;
        if (cnt >= wait_cyc) begin
          ar_ready <= 1'b1;
          cnt <= 4'h0;
        end
      end
      if (pend && !r_valid) begin
        cnt <= cnt + 4'h1;
        if (cnt >= wait_cyc) begin
          r_valid <= 1'b1;
          cnt <= 4'h0;
          // No data is returned; dirty is never passed back.
          r_resp <= {shared && is_cs, 3'h0};
        end
      end
      if (r_valid && r_ready) begin
        r_valid <= 1'b0;
        pend <= 1'b0;
        // Released response lines must not keep looking valid.
        r_resp <= ~r_resp;
      end
    end
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic ref_clk, rst_n, req_valid, req_full, st_valid, st_full;
  clms_pkg::clms_op_type req_op;
  logic [2:0] req_idx, st_idx, wb_idx, ar_idx, rd_idx, last_wb, last_ar;
  logic req_ready, req_reject, done, resp_err, wb_valid, wb_keep, wb_ready;
  logic ar_valid, ar_ready, r_valid, r_ready, shared, wb_seen, last_keep;
  logic [3:0] ar_snoop, r_resp, wait_cyc, last_snoop;
  clms_pkg::clms_line_type rd_state;
  int err_count = 0;
  int samples_checked = 0;

  clms_top #(.NUM_LINES(8)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_op(req_op), .req_idx(req_idx),
    .req_full(req_full), .req_ready(req_ready), .req_reject(req_reject),
    .done(done), .resp_err(resp_err), .st_valid(st_valid),
    .st_idx(st_idx), .st_full(st_full), .wb_valid(wb_valid),
    .wb_idx(wb_idx), .wb_keep(wb_keep), .wb_ready(wb_ready),
    .ar_valid(ar_valid), .ar_snoop(ar_snoop), .ar_idx(ar_idx),
    .ar_ready(ar_ready), .r_valid(r_valid), .r_resp(r_resp),
    .r_ready(r_ready), .rd_idx(rd_idx), .rd_state(rd_state));
  clms_ic_model partner (.ref_clk(ref_clk), .rst_n(rst_n),
    .wait_cyc(wait_cyc), .shared(shared), .ar_valid(ar_valid),
    .ar_snoop(ar_snoop), .ar_ready(ar_ready), .r_valid(r_valid),
    .r_resp(r_resp), .r_ready(r_ready), .wb_valid(wb_valid),
    .wb_ready(wb_ready));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Records the write-back and address phases seen for each operation.
  always @(posedge ref_clk) begin
    if (req_valid && req_ready) wb_seen <= 1'b0;
    else if (wb_valid && wb_ready) wb_seen <= 1'b1;
    if (wb_valid && wb_ready) begin
      last_wb <= wb_idx;
      last_keep <= wb_keep;
    end
    if (ar_valid && ar_ready) begin
      last_snoop <= ar_snoop;
      last_ar <= ar_idx;
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [3:0] exp, logic [3:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic line_is(logic [2:0] idx, clms_pkg::clms_line_type exp);
    rd_idx <= idx;
    @(posedge ref_clk);
    @(posedge ref_clk);
    chk("line state", {1'b0, exp}, {1'b0, rd_state});
  endtask

  task automatic store(logic [2:0] idx, logic full);
    @(posedge ref_clk);
    st_valid <= 1'b1;
    st_idx <= idx;
    st_full <= full;
    @(posedge ref_clk);
    st_valid <= 1'b0;
  endtask

  // Runs one operation; optionally stores to the line while it is pending.
  task automatic do_op(clms_pkg::clms_op_type op, logic [2:0] idx,
                       logic full, logic mid_st, logic exp_rej);
    int n;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_idx <= idx;
    req_full <= full;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!req_ready && n < 50);
    req_valid <= 1'b0;
    if (mid_st) begin
      st_valid <= 1'b1;
      st_idx <= idx;
      st_full <= 1'b0;
    end
    n = 0;
    do begin
      @(posedge ref_clk);
      st_valid <= 1'b0;
      n++;
    end while (!done && !req_reject && n < 100);
    if (!done && !req_reject) begin
      err_count++;
      $display("wrong value handshake expected done seen timeout");
      test_done();
    end else begin
      chk("reject", {3'h0, exp_rej}, {3'h0, req_reject});
      if (!exp_rej) begin
        chk("read address line", {1'b0, idx}, {1'b0, last_ar});
      end
    end
  endtask

  task automatic test_reset();
    line_is(3'h0, clms_pkg::LINE_I);
    chk("ready after reset", 4'h1, {3'h0, req_ready});
    $display("test reset done");
  endtask

  task automatic test_clean_shared_invalid();
    shared <= 1'b1;
    do_op(clms_pkg::OP_CLEAN_SHARED, 3'h2, 1'b0, 1'b0, 1'b0);
    line_is(3'h2, clms_pkg::LINE_I);
    chk("snoop", clms_pkg::SNOOP_CLEAN_SHARED, last_snoop);
    shared <= 1'b0;
    do_op(clms_pkg::OP_CLEAN_SHARED, 3'h2, 1'b0, 1'b0, 1'b0);
    line_is(3'h2, clms_pkg::LINE_I);
    $display("test clean_shared_invalid done");
  endtask

  task automatic test_clean_shared_dirty();
    store(3'h1, 1'b1);
    line_is(3'h1, clms_pkg::LINE_UD);
    do_op(clms_pkg::OP_CLEAN_SHARED, 3'h1, 1'b0, 1'b0, 1'b0);
    chk("write-back first", 4'h1, {3'h0, wb_seen});
    chk("write-back line", 4'h1, {1'b0, last_wb});
    chk("write-back keep", 4'h1, {3'h0, last_keep});
    line_is(3'h1, clms_pkg::LINE_UC);
    wait_cyc <= 4'h3;
    do_op(clms_pkg::OP_CLEAN_SHARED, 3'h1, 1'b0, 1'b1, 1'b0);
    line_is(3'h1, clms_pkg::LINE_UD);
    wait_cyc <= 4'h0;
    $display("test clean_shared_dirty done");
  endtask

  // Sharing reported by the interconnect demotes the line; stores still land.
  task automatic test_clean_shared_sharing();
    shared <= 1'b1;
    do_op(clms_pkg::OP_CLEAN_SHARED, 3'h1, 1'b0, 1'b0, 1'b0);
    chk("write-back first", 4'h1, {3'h0, wb_seen});
    line_is(3'h1, clms_pkg::LINE_SC);
    do_op(clms_pkg::OP_CLEAN_SHARED, 3'h1, 1'b0, 1'b0, 1'b0);
    line_is(3'h1, clms_pkg::LINE_SC);
    shared <= 1'b0;
    do_op(clms_pkg::OP_CLEAN_SHARED, 3'h1, 1'b0, 1'b0, 1'b0);
    line_is(3'h1, clms_pkg::LINE_UC);
    shared <= 1'b1;
    do_op(clms_pkg::OP_CLEAN_SHARED, 3'h1, 1'b0, 1'b0, 1'b0);
    wait_cyc <= 4'h3;
    do_op(clms_pkg::OP_CLEAN_SHARED, 3'h1, 1'b0, 1'b1, 1'b0);
    line_is(3'h1, clms_pkg::LINE_SD);
    wait_cyc <= 4'h0;
    shared <= 1'b0;
    do_op(clms_pkg::OP_MAKE_UNIQUE, 3'h1, 1'b1, 1'b0, 1'b0);
    line_is(3'h1, clms_pkg::LINE_UD);
    chk("response error", 4'h0, {3'h0, resp_err});
    $display("test clean_shared_sharing done");
  endtask

  task automatic test_clean_invalid();
    do_op(clms_pkg::OP_CLEAN_INVALID, 3'h1, 1'b0, 1'b0, 1'b0);
    chk("write-back first", 4'h1, {3'h0, wb_seen});
    chk("write-back line", 4'h1, {1'b0, last_wb});
    chk("write-back keep", 4'h0, {3'h0, last_keep});
    chk("snoop", clms_pkg::SNOOP_CLEAN_INVALID, last_snoop);
    line_is(3'h1, clms_pkg::LINE_I);
    $display("test clean_invalid done");
  endtask

  task automatic test_make_unique();
    do_op(clms_pkg::OP_MAKE_UNIQUE, 3'h3, 1'b0, 1'b0, 1'b1);
    line_is(3'h3, clms_pkg::LINE_I);
    do_op(clms_pkg::OP_MAKE_UNIQUE, 3'h3, 1'b1, 1'b0, 1'b0);
    chk("snoop", clms_pkg::SNOOP_MAKE_UNIQUE, last_snoop);
    line_is(3'h3, clms_pkg::LINE_UD);
    do_op(clms_pkg::OP_MAKE_UNIQUE, 3'h3, 1'b1, 1'b0, 1'b0);
    line_is(3'h3, clms_pkg::LINE_UD);
    chk("response error", 4'h0, {3'h0, resp_err});
    $display("test make_unique done");
  endtask

  task automatic test_make_invalid();
    do_op(clms_pkg::OP_MAKE_INVALID, 3'h3, 1'b0, 1'b0, 1'b0);
    chk("snoop", clms_pkg::SNOOP_MAKE_INVALID, last_snoop);
    line_is(3'h3, clms_pkg::LINE_I);
    do_op(clms_pkg::OP_MAKE_INVALID, 3'h3, 1'b0, 1'b0, 1'b0);
    line_is(3'h3, clms_pkg::LINE_I);
    $display("test make_invalid done");
  endtask

  initial begin
    rst_n = 1'b0;
    {req_valid, req_full, st_valid, st_full, shared} = 5'h00;
    req_op = clms_pkg::OP_CLEAN_SHARED;
    {req_idx, st_idx, rd_idx} = 9'h000;
    wait_cyc = 4'h0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_reset();
    test_clean_shared_invalid();
    test_clean_shared_dirty();
    test_clean_shared_sharing();
    test_clean_invalid();
    test_make_unique();
    test_make_invalid();
    test_done();
  end
endmodule
